// file: verilog/pmr_result_bank.sv
// result and calibration register bank of the current and power monitor
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - out-of-range shunt saturates to the range's most negative or positive code
// - shunt word is 16-bit twos complement, sign filling unused upper bits
// - read-only bus voltage register at index 02h holds latest bus result
// - 32 V range: 13-bit unsigned bus value in bits 15..3, 4 mV step
// - 16 V range: bit 15 zero, 12-bit value in bits 14..3
// - ready flag sets only after conversion, current and power are done
// - mode write clears ready flag unless new mode is power-down or disable or the write falls in the commit cycle
// - a read of the power register clears the ready flag, except in the commit cycle, where set wins
// - result registers readable any time, returning last completed results
// - overflow flag bit 0 set when current or power is out of range
// - power at index 03h is current times bus value over 5000
// - current at index 04h is shunt times calibration over 4096
// - negative current stored as 16-bit twos complement, bit 15 sign
// - calibration at index 05h is read/write; bits 15..1 used in math
// - calibration bit 0 always reads zero, writes of one ignored
// - calibration, bus, power and current registers reset to zero
module pmr_result_bank
    import pmr_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic [1:0]  SHUNT_RANGE_DIVIDER,
    input  wire logic        BUS_RANGE_32V,
    input  wire logic        CONV_DONE,
    input  wire logic [17:0] SHUNT_RAW,
    input  wire logic [12:0] BUS_RAW,
    input  wire logic        MODE_WR,
    input  wire logic [2:0]  MODE_VALUE,
    input  wire logic [7:0]  REG_INDEX,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [15:0] REG_WDATA,
    output logic      [15:0] REG_RDATA,
    output logic             REG_RVALID,
    output logic             BUSY,
    output logic             CONVERSION_READY_FLAG,
    output logic             MATH_OVERFLOW_FLAG,
    output logic      [15:0] SHUNT_RESULT
);

    // saturating shunt conversion for the selected divider
    function automatic logic [15:0] shunt_sat(input logic [17:0] raw, input logic [1:0] div);
        logic signed [17:0] lim;
        logic signed [17:0] val;
        lim = 18'(SHUNT_BASE) <<< div;
        val = $signed(raw);
        if (val > lim) begin
            shunt_sat = lim[15:0];
        end else if (val < -lim) begin
            shunt_sat = 16'((-lim));
        end else begin
            shunt_sat = val[15:0];
        end
    endfunction

    // magnitude of a twos-complement current word
    function automatic logic [31:0] abs_current(input logic [15:0] cur);
        if (cur[15]) begin
            abs_current = 32'(-$signed({{16{1'b1}}, cur}));
        end else begin
            abs_current = {16'h0, cur};
        end
    endfunction

    // power word clamped to 16 bits, overflow flag on top
    function automatic logic [16:0] power_clamp(input logic [31:0] q);
        if (q > 32'h0000_ffff) begin
            power_clamp = {1'b1, 16'hffff};
        end else begin
            power_clamp = {1'b0, q[15:0]};
        end
    endfunction

    // 16 V range keeps a 12-bit count
    function automatic logic [12:0] clamp_bus16(input logic [12:0] raw);
        if (raw > BUS16_MAX) begin
            clamp_bus16 = BUS16_MAX;
        end else begin
            clamp_bus16 = raw;
        end
    endfunction

    // modes other than power-down and disable
    function automatic logic mode_clears(input logic [2:0] m);
        mode_clears = (m != MODE_OFF) && (m != MODE_ADC_OFF);
    endfunction

    // strobe aimed at one register index
    function automatic logic reg_hit(input logic strobe, input logic [7:0] idx, input logic [7:0] want);
        reg_hit = strobe && (idx == want);
    endfunction

    pmr_state_e  state_reg, state_next;
    pmr_result_s res_reg, res_next;
    logic [15:0] shunt_s_reg, shunt_s_next;
    logic [12:0] bus_s_reg, bus_s_next;
    logic [15:0] bus_w_reg, bus_w_next;
    logic [15:0] curr_s_reg, curr_s_next;
    logic        covf_reg, covf_next;
    logic        ovf_reg, ovf_next;
    logic        rdy_reg, rdy_next;
    logic [15:0] scale_reg, scale_next;
    logic [15:0] rdata_reg, rdata_next;
    logic        rvalid_reg, rvalid_next;

    logic signed [32:0] curr_prod;
    logic signed [32:0] curr_q;
    logic        [31:0] curr_mag;
    logic        [31:0] pow_q;
    logic        [16:0] pow_w;
    logic               commit;
    logic               rdy_clear;

    always_comb begin
        state_next   = state_reg;
        shunt_s_next = shunt_s_reg;
        bus_s_next   = bus_s_reg;
        curr_s_next  = curr_s_reg;
        covf_next    = covf_reg;
        commit       = 1'b0;
        curr_prod = $signed({{17{shunt_s_reg[15]}}, shunt_s_reg}) * $signed({17'h0, scale_reg});
        curr_q    = curr_prod >>> CURR_SHIFT;
        // power from current and bus value
        curr_mag  = abs_current(curr_s_reg);
        pow_q     = (curr_mag * {19'h0, bus_s_reg}) / POWER_DIV;
        pow_w     = power_clamp(pow_q);
        case (state_reg)
            ST_IDLE: begin
                if (CONV_DONE) begin
                    shunt_s_next = shunt_sat(SHUNT_RAW, SHUNT_RANGE_DIVIDER);
                    if (BUS_RANGE_32V) begin
                        bus_s_next = BUS_RAW;
                    end else begin
                        bus_s_next = clamp_bus16(BUS_RAW);
                    end
                    state_next = ST_CURR;
                end
            end
            ST_CURR: begin
                if (curr_q > 33'sd32767) begin
                    curr_s_next = 16'h7fff;
                    covf_next   = 1'b1;
                end else if (curr_q < -33'sd32768) begin
                    curr_s_next = 16'h8000;
                    covf_next   = 1'b1;
                end else begin
                    curr_s_next = curr_q[15:0];
                    covf_next   = 1'b0;
                end
                state_next = ST_POWR;
            end
            ST_POWR: begin
                commit     = 1'b1;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_comb begin
        res_next  = res_reg;
        ovf_next  = ovf_reg;
        if (commit) begin
            res_next.shunt   = shunt_s_reg;
            res_next.current = curr_s_reg;
            ovf_next         = covf_reg || pow_w[16];
            res_next.power   = pow_w[15:0];
            res_next.bus     = {bus_s_reg, 3'h0};
        end
        bus_w_next = res_next.bus;
        bus_w_next[BUS_UNUSED] = 1'b0;
    end

    always_comb begin
        rdy_clear = 1'b0;
        if (reg_hit(REG_RD, REG_INDEX, IDX_POWER)) begin
            rdy_clear = 1'b1;
        end
        if (MODE_WR && mode_clears(MODE_VALUE)) begin
            rdy_clear = 1'b1;
        end
        // set only after both products; set wins
        if (commit) begin
            rdy_next = 1'b1;
        end else if (rdy_clear) begin
            rdy_next = 1'b0;
        end else begin
            rdy_next = rdy_reg;
        end
    end

    always_comb begin
        scale_next = scale_reg;
        if (reg_hit(REG_WR, REG_INDEX, IDX_SCALE)) begin
            scale_next = REG_WDATA & SCALE_MASK;
        end
    end

    always_comb begin
        rvalid_next = REG_RD;
        rdata_next  = rdata_reg;
        if (REG_RD) begin
            case (REG_INDEX)
                IDX_SHUNT:   rdata_next = res_reg.shunt;
                IDX_BUS: begin
                    rdata_next = bus_w_reg;
                    rdata_next[BUS_RDY_POS] = rdy_reg;
                    rdata_next[BUS_OVF_POS] = ovf_reg;
                end
                IDX_POWER:   rdata_next = res_reg.power;
                IDX_CURRENT: rdata_next = res_reg.current;
                IDX_SCALE:   rdata_next = scale_reg;
                default:     rdata_next = RST_WORD;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_reg   <= ST_IDLE;
            shunt_s_reg <= RST_WORD;
            bus_s_reg   <= 13'h0;
            curr_s_reg  <= RST_WORD;
            covf_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            shunt_s_reg <= shunt_s_next;
            bus_s_reg   <= bus_s_next;
            curr_s_reg  <= curr_s_next;
            covf_reg    <= covf_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            res_reg   <= '0;
            bus_w_reg <= RST_WORD;
            ovf_reg   <= 1'b0;
        end else begin
            res_reg   <= res_next;
            bus_w_reg <= bus_w_next;
            ovf_reg   <= ovf_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rdy_reg <= 1'b0;
        end else begin
            rdy_reg <= rdy_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            scale_reg <= RST_WORD;
        end else begin
            scale_reg <= scale_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rdata_reg  <= RST_WORD;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign REG_RDATA             = rdata_reg;
    assign REG_RVALID            = rvalid_reg;
    assign BUSY                  = (state_reg != ST_IDLE);
    assign CONVERSION_READY_FLAG = rdy_reg;
    assign MATH_OVERFLOW_FLAG    = ovf_reg;
    assign SHUNT_RESULT          = res_reg.shunt;

endmodule // pmr_result_bank

`default_nettype wire

// file: verilog/pmr_pkg.sv
// shared constants and types of the power monitor result bank
package pmr_pkg;
    localparam logic [7:0]  IDX_SHUNT    = 8'h01;
    localparam logic [7:0]  IDX_BUS      = 8'h02;
    localparam logic [7:0]  IDX_POWER    = 8'h03;
    localparam logic [7:0]  IDX_CURRENT  = 8'h04;
    localparam logic [7:0]  IDX_SCALE    = 8'h05;
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [15:0] SCALE_MASK   = 16'hfffe;
    localparam int          BUS_LSB_POS  = 3;
    localparam int          BUS_UNUSED   = 2;
    localparam int          BUS_RDY_POS  = 1;
    localparam int          BUS_OVF_POS  = 0;
    localparam logic [12:0] BUS16_MAX    = 13'h0fff;
    localparam logic [15:0] SHUNT_BASE   = 16'h0fa0;
    localparam int          CURR_SHIFT   = 12;
    localparam logic [31:0] POWER_DIV    = 32'h0000_1388;
    localparam logic [2:0]  MODE_OFF     = 3'h0;
    localparam logic [2:0]  MODE_ADC_OFF = 3'h4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CURR = 2'b01,
        ST_POWR = 2'b10
    } pmr_state_e;

    typedef struct packed {
        logic [15:0] shunt;
        logic [15:0] bus;
        logic [15:0] current;
        logic [15:0] power;
    } pmr_result_s;
endpackage

// file: test/pmr_result_checker.sv
// port checker for the result bank
`timescale 1ns/1ps
`default_nettype none
module pmr_result_checker
    import pmr_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RESET,
    input wire logic        CONV_DONE,
    input wire logic        MODE_WR,
    input wire logic [2:0]  MODE_VALUE,
    input wire logic [7:0]  REG_INDEX,
    input wire logic        REG_RD,
    input wire logic [15:0] REG_RDATA,
    input wire logic        REG_RVALID,
    input wire logic        BUSY,
    input wire logic        CONVERSION_READY_FLAG,
    input wire logic        MATH_OVERFLOW_FLAG,
    input wire logic [15:0] SHUNT_RESULT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    a_read_answer: assert property (REG_RD |=> REG_RVALID)
        else $error("read answer missing");
    a_no_spurious: assert property (!REG_RD |=> !REG_RVALID)
        else $error("read answer without read");
    a_conv_commit: assert property (CONV_DONE && !BUSY |=> BUSY ##1 BUSY ##1 (!BUSY && CONVERSION_READY_FLAG))
        else $error("commit timing wrong");
    a_ready_source: assert property ($rose(CONVERSION_READY_FLAG) |-> $past(BUSY))
        else $error("ready rose without compute");
    a_power_clear: assert property (REG_RD && REG_INDEX == IDX_POWER && !(BUSY && $past(BUSY)) |=> !CONVERSION_READY_FLAG)
        else $error("power read kept ready");
    a_mode_clear: assert property (MODE_WR && MODE_VALUE != MODE_OFF && MODE_VALUE != MODE_ADC_OFF
        && !(BUSY && $past(BUSY)) |=> !CONVERSION_READY_FLAG)
        else $error("mode write kept ready");
    a_mode_keep: assert property (MODE_WR && (MODE_VALUE == MODE_OFF || MODE_VALUE == MODE_ADC_OFF)
        && CONVERSION_READY_FLAG && !(REG_RD && REG_INDEX == IDX_POWER) |=> CONVERSION_READY_FLAG)
        else $error("idle mode cleared ready");
    a_results_held: assert property (!(BUSY && $past(BUSY)) |=> $stable(SHUNT_RESULT) && $stable(MATH_OVERFLOW_FLAG))
        else $error("result changed outside commit");
    a_scale_void: assert property (REG_RVALID && $past(REG_INDEX) == IDX_SCALE |-> !REG_RDATA[0])
        else $error("scale bit 0 set");
    a_bus_spare: assert property (REG_RVALID && $past(REG_INDEX) == IDX_BUS |-> !REG_RDATA[BUS_UNUSED])
        else $error("bus spare bit set");
endmodule // pmr_result_checker
bind pmr_result_bank pmr_result_checker u_chk (.CLK(CLK), .RESET(RESET), .CONV_DONE(CONV_DONE), .MODE_WR(MODE_WR),
    .MODE_VALUE(MODE_VALUE), .REG_INDEX(REG_INDEX), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .BUSY(BUSY), .CONVERSION_READY_FLAG(CONVERSION_READY_FLAG), .MATH_OVERFLOW_FLAG(MATH_OVERFLOW_FLAG),
    .SHUNT_RESULT(SHUNT_RESULT));
`default_nettype wire

// file: test/pmr_host_model.sv
// register host model on the bank's register port
`timescale 1ns/1ps
`default_nettype none
module pmr_host_model (
    input  wire logic        CLK,
    input  wire logic [15:0] REG_RDATA,
    output logic      [7:0]  REG_INDEX,
    output logic             REG_WR,
    output logic             REG_RD,
    output logic      [15:0] REG_WDATA
);
    initial {REG_INDEX, REG_WR, REG_RD, REG_WDATA} = 26'h0;
    // released index and data lines show the inverse of their last value; both strobes drop low
    task automatic xfer(input logic [7:0] i, input logic wr, input logic [15:0] wd, output logic [15:0] rd_d);
        @(posedge CLK);
        #1 {REG_INDEX, REG_WR, REG_RD, REG_WDATA} = {i, wr, !wr, wd};
        @(posedge CLK);
        #1 {REG_INDEX, REG_WR, REG_RD, REG_WDATA} = {~i, 1'b0, 1'b0, ~wd};
        rd_d = REG_RDATA;
    endtask
endmodule // pmr_host_model
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench for the result bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pmr_pkg::*;
    typedef struct {logic [1:0] div; logic r32; logic [17:0] raw; logic [12:0] bus; logic [15:0] cal, shunt;} pmr_row_s;
    logic        CLK = 1'b0, RESET = 1'b1, BUS_RANGE_32V = 1'b0, CONV_DONE = 1'b0, MODE_WR = 1'b0;
    logic [1:0]  SHUNT_RANGE_DIVIDER = 2'h0;
    logic [17:0] SHUNT_RAW = 18'h0;
    logic [12:0] BUS_RAW = 13'h0;
    logic [2:0]  MODE_VALUE = 3'h0;
    logic [7:0]  REG_INDEX;
    logic        REG_WR, REG_RD, REG_RVALID, BUSY, CONVERSION_READY_FLAG, MATH_OVERFLOW_FLAG;
    logic [15:0] REG_WDATA, REG_RDATA, SHUNT_RESULT, d, ec, ep;
    logic        eo;
    int          err_total = 0, n_compared = 0;
    pmr_row_s    rows [7] = '{
        '{2'h3, 1'b1, 18'h382fe, 13'h1f40, 16'h1001, 16'h8300}, '{2'h2, 1'b1, 18'h3c17f, 13'h1f40, 16'h1001, 16'hc180},
        '{2'h1, 1'b0, 18'h3e0bf, 13'h0fa0, 16'h1001, 16'he0c0}, '{2'h0, 1'b0, 18'h3f05f, 13'h0fa0, 16'h1001, 16'hf060},
        '{2'h0, 1'b1, 18'h00f9f, 13'h0001, 16'h2000, 16'h0f9f}, '{2'h3, 1'b1, 18'h07d02, 13'h1f40, 16'h1001, 16'h7d00},
        '{2'h3, 1'b1, 18'h07d00, 13'h1f40, 16'hffff, 16'h7d00}};
    pmr_result_bank uut (.CLK(CLK), .RESET(RESET), .SHUNT_RANGE_DIVIDER(SHUNT_RANGE_DIVIDER),
        .BUS_RANGE_32V(BUS_RANGE_32V), .CONV_DONE(CONV_DONE), .SHUNT_RAW(SHUNT_RAW), .BUS_RAW(BUS_RAW),
        .MODE_WR(MODE_WR), .MODE_VALUE(MODE_VALUE), .REG_INDEX(REG_INDEX), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .BUSY(BUSY),
        .CONVERSION_READY_FLAG(CONVERSION_READY_FLAG), .MATH_OVERFLOW_FLAG(MATH_OVERFLOW_FLAG),
        .SHUNT_RESULT(SHUNT_RESULT));
    pmr_host_model host (.CLK(CLK), .REG_RDATA(REG_RDATA), .REG_INDEX(REG_INDEX), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_WDATA(REG_WDATA));
    always #10 CLK = ~CLK;
    function automatic void calc(input logic [15:0] s, cal, input logic [12:0] bv,
                                 output logic [15:0] cur, pw, output logic ov);
        longint c, p;
        c = (longint'($signed(s)) * longint'(cal & SCALE_MASK)) >>> CURR_SHIFT;
        ov = c > 64'sh7fff || c < -64'sh8000;
        c = ov ? (c < 0 ? -64'sh8000 : 64'sh7fff) : c;
        p = (c < 0 ? -c : c) * longint'(bv) / longint'(POWER_DIV);
        cur = c[15:0];
        pw = p > 64'shffff ? 16'hffff : p[15:0];
        ov = ov | (p > 64'shffff);
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conv(input pmr_row_s r);
        @(posedge CLK);
        #1 {SHUNT_RANGE_DIVIDER, BUS_RANGE_32V, SHUNT_RAW, BUS_RAW, CONV_DONE} = {r.div, r.r32, r.raw, r.bus, 1'b1};
        @(posedge CLK);
        #1 CONV_DONE = 1'b0;
        repeat (2) @(posedge CLK);
        #1;
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #200000 err_total++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge CLK);
        #1 RESET = 1'b0;
        foreach (rows[i]) begin
            host.xfer(IDX_SCALE, 1'b1, rows[i].cal, d);
            conv(rows[i]);
            calc(rows[i].shunt, rows[i].cal, rows[i].bus, ec, ep, eo);
            chk("shunt", rows[i].shunt, SHUNT_RESULT);
            chk("overflow", {15'h0, eo}, {15'h0, MATH_OVERFLOW_FLAG});
            host.xfer(IDX_BUS, 1'b0, 16'h0, d);
            chk("bus", {rows[i].bus, 3'h0} | {14'h0, 1'b1, eo}, d);
            host.xfer(IDX_CURRENT, 1'b0, 16'h0, d);
            chk("current", ec, d);
            host.xfer(IDX_SCALE, 1'b0, 16'h0, d);
            chk("scale", rows[i].cal & SCALE_MASK, d);
            host.xfer(IDX_POWER, 1'b0, 16'h0, d);
            chk("power", ep, d);
            chk("ready", 16'h0, {15'h0, CONVERSION_READY_FLAG});
        end
        for (int m = 0; m < 8; m++) begin
            conv(rows[0]);
            {MODE_VALUE, MODE_WR} = {m[2:0], 1'b1};
            @(posedge CLK);
            #1 MODE_WR = 1'b0;
            chk("mode ready", {15'h0, m == 0 || m == 4}, {15'h0, CONVERSION_READY_FLAG});
        end
        conv(rows[5]);
        #0 CONV_DONE = 1'b1;
        @(posedge CLK);
        #1 {SHUNT_RAW, CONV_DONE} = {rows[0].raw, 1'b1};
        @(posedge CLK);
        #1 CONV_DONE = 1'b0;
        @(posedge CLK);
        #1 chk("busy drop", 16'h7d00, SHUNT_RESULT);
        host.xfer(IDX_CURRENT, 1'b1, 16'h1234, d);
        host.xfer(IDX_CURRENT, 1'b0, 16'h0, d);
        chk("read only", ec, d);
        host.xfer(8'h3c, 1'b0, 16'h0, d);
        chk("unmapped", 16'h0, d);
        @(posedge CLK);
        #1 RESET = 1'b1;
        repeat (4) @(posedge CLK);
        #1 RESET = 1'b0;
        for (int r = 2; r < 6; r++) begin
            host.xfer(r[7:0], 1'b0, 16'h0, d);
            chk("reset value", RST_WORD, d);
        end
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
